// File: ppd_top.sv
// Behaviour
// - each port group except can receive has a writable bit that switches its pull load on.
// - a set drive bit runs that group's outputs at reduced strength.
// - pull bits for A, B, E, H, J, K sit in one register, A B H J K off.
// - port E pull resets on, covers pins 7 and 3:0, pins 6:4 have none.
// - drive bits for A, B, E, H, J, K reset to full, each bit covers all pins of its port.
// - ports H and J take a pull-up or pull-down, enables reset off.
// - port P pull and drive bits sit in the pwm register, reset off/full.
// - port S pull and drive bits sit in the serial register, pull on.
// - port T pull and drive bits sit in timer mask two, reset off/full.
// - bus port pins 7:4 pull and drive have their own register, off/full.
// - can receive pins always pulled up, transmit pins have nothing.
// - a pull applies only to input pins, never to output pins; here a pin turned output keeps its load until the next edge with ce_i high.
//
// Chosen here: the Wishbone interface to the registers.
module ppd_top #(
    parameter int ADR_W = 10,
    parameter int NUM_CAN = 2,
    parameter int P_W = 4,
    parameter int IB_W = 4
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pin directions, high means output
    input wire logic [7:0] dir_out_a_i,
    input wire logic [7:0] dir_out_b_i,
    input wire logic [7:0] dir_out_e_i,
    input wire logic [7:0] dir_out_h_i,
    input wire logic [7:0] dir_out_j_i,
    input wire logic [7:0] dir_out_k_i,
    input wire logic [P_W-1:0] dir_out_p_i,
    input wire logic [7:0] dir_out_s_i,
    input wire logic [7:0] dir_out_t_i,
    input wire logic [IB_W-1:0] dir_out_ib_i,
    // pull polarity for h and j, high means pull-down
    input wire logic [7:0] pull_down_sel_h_i,
    input wire logic [7:0] pull_down_sel_j_i,
    // pull-up loads per pin
    output logic [7:0] pull_up_a_o,
    output logic [7:0] pull_up_b_o,
    output logic [7:0] pull_up_e_o,
    output logic [7:0] pull_up_h_o,
    output logic [7:0] pull_up_j_o,
    output logic [7:0] pull_up_k_o,
    output logic [P_W-1:0] pull_up_p_o,
    output logic [7:0] pull_up_s_o,
    output logic [7:0] pull_up_t_o,
    output logic [IB_W-1:0] pull_up_ib_o,
    output logic [NUM_CAN-1:0] pull_up_can_rx_o,
    // pull-down loads per pin
    output logic [7:0] pull_down_h_o,
    output logic [7:0] pull_down_j_o,
    // reduced drive per group
    output logic low_drive_a_o,
    output logic low_drive_b_o,
    output logic low_drive_e_o,
    output logic low_drive_h_o,
    output logic low_drive_j_o,
    output logic low_drive_k_o,
    output logic low_drive_p_o,
    output logic low_drive_s_o,
    output logic low_drive_t_o,
    output logic low_drive_bus_o
);

    localparam int IW = ADR_W - 2;

    logic [7:0] pull_enable_control;
    logic [7:0] drive_strength_control;
    logic [1:0] pwm_control_register;
    logic [1:0] timer_mask_two;
    logic [1:0] serial_periph_control_two;
    logic [1:0] bus_port_pull_drive_control;
    logic [NUM_CAN-1:0] can_pull;
    logic [7:0] next_pull;
    logic [7:0] next_drive;
    logic [1:0] next_pwm;
    logic [1:0] next_timer;
    logic [1:0] next_serial;
    logic [1:0] next_bus_port;
    logic [31:0] next_dat;
    logic next_ack;
    logic req;
    logic wr;
    logic [7:0] wr_byte;

    // word index match for an address
    function automatic logic hit(input logic [ADR_W-1:0] adr,
                                 input logic [7:0] idx);
        hit = (adr[ADR_W-1:2] == IW'(idx));
    endfunction

    // place a pull and drive pair in a byte
    function automatic logic [7:0] pair_byte(input logic [1:0] pair);
        logic [7:0] b;
        b = 8'h00;
        b[ppd_pkg::BIT_SH_PULL] = pair[1];
        b[ppd_pkg::BIT_SH_DRIVE] = pair[0];
        pair_byte = b;
    endfunction

    // take a pull and drive pair from a byte
    function automatic logic [1:0] byte_pair(input logic [7:0] b);
        byte_pair = {b[ppd_pkg::BIT_SH_PULL], b[ppd_pkg::BIT_SH_DRIVE]};
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    // bus decode, register writes and read data
    always_comb
    begin
        next_pull = pull_enable_control;
        next_drive = drive_strength_control;
        next_pwm = pwm_control_register;
        next_timer = timer_mask_two;
        next_serial = serial_periph_control_two;
        next_bus_port = bus_port_pull_drive_control;
        next_ack = req;
        next_dat = 32'h0000_0000;
        if (wr && hit(wb_adr_i, ppd_pkg::IDX_PULL))
            next_pull = wr_byte & ppd_pkg::GROUP_MASK;
        if (wr && hit(wb_adr_i, ppd_pkg::IDX_DRIVE))
            next_drive = wr_byte & ppd_pkg::GROUP_MASK;
        if (wr && hit(wb_adr_i, ppd_pkg::IDX_PWM))
            next_pwm = byte_pair(wr_byte);
        if (wr && hit(wb_adr_i, ppd_pkg::IDX_TIMER))
            next_timer = byte_pair(wr_byte);
        if (wr && hit(wb_adr_i, ppd_pkg::IDX_SERIAL))
            next_serial = byte_pair(wr_byte);
        if (wr && hit(wb_adr_i, ppd_pkg::IDX_BUS_PORT))
            next_bus_port = byte_pair(wr_byte);
        if (req && !wb_we_i)
        begin
            // readback of stored bits
            if (hit(wb_adr_i, ppd_pkg::IDX_PULL))
                next_dat[7:0] = pull_enable_control;
            else if (hit(wb_adr_i, ppd_pkg::IDX_DRIVE))
                next_dat[7:0] = drive_strength_control;
            else if (hit(wb_adr_i, ppd_pkg::IDX_PWM))
                next_dat[7:0] = pair_byte(pwm_control_register);
            else if (hit(wb_adr_i, ppd_pkg::IDX_TIMER))
                next_dat[7:0] = pair_byte(timer_mask_two);
            else if (hit(wb_adr_i, ppd_pkg::IDX_SERIAL))
                next_dat[7:0] = pair_byte(serial_periph_control_two);
            else if (hit(wb_adr_i, ppd_pkg::IDX_BUS_PORT))
                next_dat[7:0] = pair_byte(bus_port_pull_drive_control);
        end
    end

    // register file and bus answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pull_enable_control <= ppd_pkg::PULL_RST;
            drive_strength_control <= ppd_pkg::DRIVE_RST;
            pwm_control_register <= ppd_pkg::PWM_RST;
            timer_mask_two <= ppd_pkg::TIMER_RST;
            serial_periph_control_two <= ppd_pkg::SERIAL_RST;
            bus_port_pull_drive_control <= ppd_pkg::BUS_PORT_RST;
            can_pull <= '1;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            pull_enable_control <= next_pull;
            drive_strength_control <= next_drive;
            pwm_control_register <= next_pwm;
            timer_mask_two <= next_timer;
            serial_periph_control_two <= next_serial;
            bus_port_pull_drive_control <= next_bus_port;
            can_pull <= '1;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // drive strength straight from stored bits
    assign low_drive_a_o = drive_strength_control[ppd_pkg::BIT_A];
    assign low_drive_b_o = drive_strength_control[ppd_pkg::BIT_B];
    assign low_drive_e_o = drive_strength_control[ppd_pkg::BIT_E];
    assign low_drive_h_o = drive_strength_control[ppd_pkg::BIT_H];
    assign low_drive_j_o = drive_strength_control[ppd_pkg::BIT_J];
    assign low_drive_k_o = drive_strength_control[ppd_pkg::BIT_K];
    assign low_drive_p_o = pwm_control_register[0];
    assign low_drive_t_o = timer_mask_two[0];
    assign low_drive_s_o = serial_periph_control_two[0];
    assign low_drive_bus_o = bus_port_pull_drive_control[0];
    assign pull_up_can_rx_o = can_pull;

    // pull loads per port group
    ppd_pad_group #(.W(8)) u_a (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pull_enable_control[ppd_pkg::BIT_A]),
        .dir_out_i(dir_out_a_i), .pull_down_sel_i(8'h00),
        .pull_up_o(pull_up_a_o), .pull_down_o());
    ppd_pad_group #(.W(8)) u_b (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pull_enable_control[ppd_pkg::BIT_B]),
        .dir_out_i(dir_out_b_i), .pull_down_sel_i(8'h00),
        .pull_up_o(pull_up_b_o), .pull_down_o());
    // pins 6:4 excluded by mask
    ppd_pad_group #(.W(8), .PIN_MASK(ppd_pkg::PIN_MASK_E)) u_e (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pull_enable_control[ppd_pkg::BIT_E]),
        .dir_out_i(dir_out_e_i), .pull_down_sel_i(8'h00),
        .pull_up_o(pull_up_e_o), .pull_down_o());
    // up or down on h and j
    ppd_pad_group #(.W(8)) u_h (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pull_enable_control[ppd_pkg::BIT_H]),
        .dir_out_i(dir_out_h_i), .pull_down_sel_i(pull_down_sel_h_i),
        .pull_up_o(pull_up_h_o), .pull_down_o(pull_down_h_o));
    ppd_pad_group #(.W(8)) u_j (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pull_enable_control[ppd_pkg::BIT_J]),
        .dir_out_i(dir_out_j_i), .pull_down_sel_i(pull_down_sel_j_i),
        .pull_up_o(pull_up_j_o), .pull_down_o(pull_down_j_o));
    ppd_pad_group #(.W(8), .PIN_MASK(ppd_pkg::PIN_MASK_K)) u_k (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pull_enable_control[ppd_pkg::BIT_K]),
        .dir_out_i(dir_out_k_i), .pull_down_sel_i(8'h00),
        .pull_up_o(pull_up_k_o), .pull_down_o());
    ppd_pad_group #(.W(P_W)) u_p (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(pwm_control_register[1]),
        .dir_out_i(dir_out_p_i), .pull_down_sel_i({P_W{1'b0}}),
        .pull_up_o(pull_up_p_o), .pull_down_o());
    ppd_pad_group #(.W(8)) u_s (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(serial_periph_control_two[1]),
        .dir_out_i(dir_out_s_i), .pull_down_sel_i(8'h00),
        .pull_up_o(pull_up_s_o), .pull_down_o());
    ppd_pad_group #(.W(8)) u_t (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(timer_mask_two[1]),
        .dir_out_i(dir_out_t_i), .pull_down_sel_i(8'h00),
        .pull_up_o(pull_up_t_o), .pull_down_o());
    ppd_pad_group #(.W(IB_W)) u_ib (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .pull_en_i(bus_port_pull_drive_control[1]),
        .dir_out_i(dir_out_ib_i), .pull_down_sel_i({IB_W{1'b0}}),
        .pull_up_o(pull_up_ib_o), .pull_down_o());

    // general pull register after reset
    property p_pull_reset;
        @(posedge clk_i) rst_i |=> pull_enable_control == 8'h10;
    endproperty
    a_pull_reset: assert property (p_pull_reset)
        else $error("pull register reset value wrong");

    // port e pull reaches an input pin one edge after reset
    property p_e_pull_on;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) && ce_i && !dir_out_e_i[7] |=> pull_up_e_o[7];
    endproperty
    a_e_pull_on: assert property (p_e_pull_on)
        else $error("port e pull not on after reset");

    // drive register after reset
    property p_drive_reset;
        @(posedge clk_i) rst_i |=> drive_strength_control == 8'h00
            && !low_drive_p_o && !low_drive_t_o && !low_drive_s_o;
    endproperty
    a_drive_reset: assert property (p_drive_reset)
        else $error("drive bits not at full after reset");

    // peripheral pull bits after reset
    property p_periph_reset;
        @(posedge clk_i) rst_i |=> serial_periph_control_two == 2'h2
            && pwm_control_register == 2'h0 && timer_mask_two == 2'h0
            && bus_port_pull_drive_control == 2'h0;
    endproperty
    a_periph_reset: assert property (p_periph_reset)
        else $error("peripheral pull reset wrong");

    // a pull register write lands at the ack edge
    property p_pull_write;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr && hit(wb_adr_i, ppd_pkg::IDX_PULL)
        |=> wb_ack_o && pull_enable_control == ($past(wb_dat_i[7:0]) & 8'hF3);
    endproperty
    a_pull_write: assert property (p_pull_write)
        else $error("pull register write lost");

    // drive output follows the stored bit
    property p_drive_follow;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr && hit(wb_adr_i, ppd_pkg::IDX_DRIVE)
        |=> low_drive_h_o == $past(wb_dat_i[5]);
    endproperty
    a_drive_follow: assert property (p_drive_follow)
        else $error("reduced drive output wrong");

    // can receive pull stays on
    property p_can_pull;
        @(posedge clk_i) disable iff (rst_i) pull_up_can_rx_o == '1;
    endproperty
    a_can_pull: assert property (p_can_pull)
        else $error("can receive pull dropped");

    // serial register reads back as stored
    property p_readback;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && req && !wb_we_i && hit(wb_adr_i, ppd_pkg::IDX_SERIAL)
        |=> wb_ack_o
            && wb_dat_o == {28'h0, $past(serial_periph_control_two), 2'h0};
    endproperty
    a_readback: assert property (p_readback)
        else $error("serial register readback wrong");

    // ack lasts one cycle
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

endmodule

// File: ppd_pkg.sv
package ppd_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PULL = 8'h0C;
    localparam logic [7:0] IDX_DRIVE = 8'h0D;
    localparam logic [7:0] IDX_PWM = 8'h54;
    localparam logic [7:0] IDX_TIMER = 8'h8D;
    localparam logic [7:0] IDX_SERIAL = 8'hD1;
    localparam logic [7:0] IDX_BUS_PORT = 8'hE5;

    // bit positions shared by the pull and drive registers
    localparam int BIT_A = 0;
    localparam int BIT_B = 1;
    localparam int BIT_E = 4;
    localparam int BIT_H = 5;
    localparam int BIT_J = 6;
    localparam int BIT_K = 7;
    localparam logic [7:0] GROUP_MASK = 8'hF3;

    // pull and drive bit positions in the four peripheral registers
    localparam int BIT_SH_PULL = 3;
    localparam int BIT_SH_DRIVE = 2;

    // values after reset
    localparam logic [7:0] PULL_RST = 8'h10;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    localparam logic [1:0] PWM_RST = 2'h0;
    localparam logic [1:0] TIMER_RST = 2'h0;
    localparam logic [1:0] SERIAL_RST = 2'h2;
    localparam logic [1:0] BUS_PORT_RST = 2'h0;

    // pins that carry a resistive load
    localparam logic [7:0] PIN_MASK_E = 8'h8F;
    localparam logic [7:0] PIN_MASK_K = 8'h8F;

endpackage

// File: ppd_pad_group.sv
module ppd_pad_group #(
    parameter int W = 8,
    parameter logic [W-1:0] PIN_MASK = '1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // control
    input wire logic pull_en_i,
    input wire logic [W-1:0] dir_out_i,
    input wire logic [W-1:0] pull_down_sel_i,
    // pad loads
    output logic [W-1:0] pull_up_o,
    output logic [W-1:0] pull_down_o
);

    logic [W-1:0] next_up;
    logic [W-1:0] next_down;

    // load only input pins that own a load
    always_comb
    begin
        next_up = '0;
        next_down = '0;
        for (int i = 0; i < W; i++)
        begin
            if (pull_en_i && !dir_out_i[i] && PIN_MASK[i])
            begin
                next_up[i] = !pull_down_sel_i[i];
                next_down[i] = pull_down_sel_i[i];
            end
        end
    end

    // register pad loads
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pull_up_o <= '0;
            pull_down_o <= '0;
        end
        else if (ce_i)
        begin
            pull_up_o <= next_up;
            pull_down_o <= next_down;
        end
    end

    // output pins never loaded
    property p_out_unloaded;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> ((pull_up_o | pull_down_o) & $past(dir_out_i)) == '0;
    endproperty
    a_out_unloaded: assert property (p_out_unloaded)
        else $error("output pin carries a pull load");

    // pins without a load stay free
    property p_no_load_pins;
        @(posedge clk_i) disable iff (rst_i)
        ((pull_up_o | pull_down_o) & ~PIN_MASK) == '0;
    endproperty
    a_no_load_pins: assert property (p_no_load_pins)
        else $error("unloaded pin shows a pull");

endmodule

// File: tb_port_pull_and_drive_control.sv
module tb_port_pull_and_drive_control;
    timeunit 1ns;
    timeprecision 1ps;

    // order of the 8-bit ports in the arrays: a b e h j k s t
    logic clk_i;
    logic rst_i;
    logic ce_i;
    logic wb_cyc, wb_stb, wb_we;
    logic [9:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic wb_ack;
    logic [7:0] dir [8];
    logic [7:0] pu [8];
    logic [3:0] dir_p, dir_ib, pu_p, pu_ib;
    logic [7:0] pd_h, pd_j, pdn_h, pdn_j;
    logic [1:0] pu_can;
    logic [9:0] ld;
    int error_cnt = 0;
    int comparisons = 0;
    // peripheral registers in the order p s t ib
    logic [7:0] per_idx [4] = '{ppd_pkg::IDX_PWM, ppd_pkg::IDX_SERIAL,
        ppd_pkg::IDX_TIMER, ppd_pkg::IDX_BUS_PORT};

    ppd_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .dir_out_a_i(dir[0]), .dir_out_b_i(dir[1]), .dir_out_e_i(dir[2]),
        .dir_out_h_i(dir[3]), .dir_out_j_i(dir[4]), .dir_out_k_i(dir[5]),
        .dir_out_p_i(dir_p), .dir_out_s_i(dir[6]), .dir_out_t_i(dir[7]),
        .dir_out_ib_i(dir_ib),
        .pull_down_sel_h_i(pd_h), .pull_down_sel_j_i(pd_j),
        .pull_up_a_o(pu[0]), .pull_up_b_o(pu[1]), .pull_up_e_o(pu[2]),
        .pull_up_h_o(pu[3]), .pull_up_j_o(pu[4]), .pull_up_k_o(pu[5]),
        .pull_up_p_o(pu_p), .pull_up_s_o(pu[6]), .pull_up_t_o(pu[7]),
        .pull_up_ib_o(pu_ib), .pull_up_can_rx_o(pu_can),
        .pull_down_h_o(pdn_h), .pull_down_j_o(pdn_j),
        .low_drive_a_o(ld[0]), .low_drive_b_o(ld[1]), .low_drive_e_o(ld[2]),
        .low_drive_h_o(ld[3]), .low_drive_j_o(ld[4]), .low_drive_k_o(ld[5]),
        .low_drive_p_o(ld[6]), .low_drive_s_o(ld[7]), .low_drive_t_o(ld[8]),
        .low_drive_bus_o(ld[9])
    );

    // free running clock
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg,
                     seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one classic wishbone cycle, waits for ack under a bound
    task automatic xfer(input logic [7:0] idx, input logic w,
                        input logic [7:0] d, input logic [3:0] s,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_sel <= s;
        wb_wdat <= {24'h000000, d};
        forever
        begin
            @(posedge clk_i);
            n++;
            if (wb_ack === 1'b1 || n > 50)
                break;
        end
        if (n > 50)
            chk(32'h00000000, 32'h00000001, "no acknowledge");
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        xfer(idx, 1'b1, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        xfer(idx, 1'b0, 8'h00, 4'hF, q);
        chk(q, {24'h000000, exp}, "register read");
    endtask

    // expected pad loads from pull register and p s t ib pull bits
    task automatic check_pads(input logic [7:0] pr, input logic [3:0] per);
        logic [7:0] en;
        logic [7:0] m;
        logic [7:0] ps;
        repeat (3) @(posedge clk_i);
        en = {per[2], per[1], pr[7], pr[6], pr[5], pr[4], pr[1], pr[0]};
        for (int i = 0; i < 8; i++)
        begin
            m = (i == 2 || i == 5) ? 8'h8F : 8'hFF;
            ps = (i == 3) ? pd_h : (i == 4) ? pd_j : 8'h00;
            m = m & {8{en[i]}} & ~dir[i] & ~ps;
            chk(pu[i], {24'h000000, m}, "up");
        end
        m = {8{en[3]}} & ~dir[3] & pd_h;
        chk(pdn_h, {24'h000000, m}, "down h");
        m = {8{en[4]}} & ~dir[4] & pd_j;
        chk(pdn_j, {24'h000000, m}, "down j");
        chk(pu_p, {28'h0000000, {4{per[0]}} & ~dir_p}, "up p");
        chk(pu_ib, {28'h0000000, {4{per[3]}} & ~dir_ib}, "up ib");
        chk(pu_can, 32'h00000003, "can receive");
    endtask

    // reset values of every register and pad
    task automatic t_reset;
        rd_chk(ppd_pkg::IDX_PULL, 8'h10);
        rd_chk(ppd_pkg::IDX_DRIVE, 8'h00);
        rd_chk(ppd_pkg::IDX_PWM, 8'h00);
        rd_chk(ppd_pkg::IDX_SERIAL, 8'h08);
        rd_chk(ppd_pkg::IDX_TIMER, 8'h00);
        rd_chk(ppd_pkg::IDX_BUS_PORT, 8'h00);
        check_pads(8'h10, 4'b0010);
        chk(ld, 32'h00000000, "drive after reset");
        $display("test reset done");
    endtask

    // clock enable freeze, then a second reset in mid-run
    task automatic t_hold;
        @(posedge clk_i);
        ce_i <= 1'b0;
        dir[6] <= 8'hFF;
        repeat (3) @(posedge clk_i);
        chk(pu[6], 32'h000000FF, "frozen pads");
        ce_i <= 1'b1;
        check_pads(8'h10, 4'b0010);
        dir[6] <= 8'h00;
        wr(ppd_pkg::IDX_PULL, 8'hF3);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(ppd_pkg::IDX_PULL, 8'h10);
        check_pads(8'h10, 4'b0010);
        $display("test hold and reset done");
    endtask

    // readback, reserved bits, byte enable, unmapped place
    task automatic t_regs;
        logic [31:0] q;
        wr(ppd_pkg::IDX_PULL, 8'hFF);
        rd_chk(ppd_pkg::IDX_PULL, 8'hF3);
        wr(ppd_pkg::IDX_DRIVE, 8'hFF);
        rd_chk(ppd_pkg::IDX_DRIVE, 8'hF3);
        for (int i = 0; i < 4; i++)
        begin
            wr(per_idx[i], 8'hFF);
            rd_chk(per_idx[i], 8'h0C);
        end
        chk(ld, 32'h000003FF, "all reduced");
        xfer(ppd_pkg::IDX_DRIVE, 1'b1, 8'h00, 4'hE, q);
        rd_chk(ppd_pkg::IDX_DRIVE, 8'hF3);
        xfer(8'h0E, 1'b1, 8'hFF, 4'hF, q);
        chk(q, 32'h00000000, "write data out");
        rd_chk(8'h0E, 8'h00);
        rd_chk(ppd_pkg::IDX_PULL, 8'hF3);
        wr(ppd_pkg::IDX_DRIVE, 8'h00);
        for (int i = 0; i < 4; i++)
            wr(per_idx[i], 8'h00);
        chk(ld, 32'h00000000, "all full");
        $display("test registers done");
    endtask

    // each reduced drive bit alone drives only its own group
    task automatic t_drive;
        int pos [6] = '{0, 1, 4, 5, 6, 7};
        for (int k = 0; k < 10; k++)
        begin
            if (k < 6)
                wr(ppd_pkg::IDX_DRIVE, 8'h01 << pos[k]);
            else
                wr(per_idx[k-6], 8'h04);
            chk(ld, 32'h00000001 << k, "one reduced");
            if (k < 6)
                wr(ppd_pkg::IDX_DRIVE, 8'h00);
            else
                wr(per_idx[k-6], 8'h00);
        end
        $display("test drive done");
    endtask

    // pull loads against direction and polarity
    task automatic t_pads;
        wr(ppd_pkg::IDX_PULL, 8'hF3);
        for (int i = 0; i < 4; i++)
            wr(per_idx[i], 8'h08);
        for (int i = 0; i < 8; i++)
            dir[i] <= 8'h5A ^ 8'(i * 17);
        dir_p <= 4'h5;
        dir_ib <= 4'h3;
        pd_h <= 8'h0F;
        pd_j <= 8'hF0;
        check_pads(8'hF3, 4'hF);
        for (int i = 0; i < 8; i++)
            dir[i] <= 8'hFF;
        dir_p <= 4'hF;
        dir_ib <= 4'hF;
        check_pads(8'hF3, 4'hF);
        for (int i = 0; i < 8; i++)
            dir[i] <= 8'h00;
        dir_p <= 4'h0;
        dir_ib <= 4'h0;
        wr(ppd_pkg::IDX_PULL, 8'h00);
        for (int i = 0; i < 4; i++)
            wr(per_idx[i], 8'h00);
        check_pads(8'h00, 4'h0);
        $display("test pads done");
    endtask

    // main sequence
    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 10'h000;
        wb_sel = 4'h0;
        wb_wdat = 32'h00000000;
        for (int i = 0; i < 8; i++)
            dir[i] = 8'h00;
        dir_p = 4'h0;
        dir_ib = 4'h0;
        pd_h = 8'h00;
        pd_j = 8'h00;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_hold;
        t_regs;
        t_drive;
        t_pads;
        conclude;
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        conclude;
    end
endmodule
